// *** include/swdc_pkg.sv ***
package swdc_pkg;

	// Greatest common divisor, used only at elaboration
	function automatic int swdc_gcd(input int a, input int b);
		int x;
		int y;
		int t;
		x = a;
		y = b;
		for (int i = 0; i < 64; i++) begin
			if (y != 0) begin
				t = y;
				y = x % y;
				x = t;
			end
		end
		return x;
	endfunction

	// Stream geometry: bytes per beat, width ratios and field widths
	localparam int SWDC_IN_BYTES      = 4;
	localparam int SWDC_OUT_BYTES     = 6;
	localparam int SWDC_LCM_BYTES     = SWDC_IN_BYTES * SWDC_OUT_BYTES
	                                    / swdc_gcd(SWDC_IN_BYTES, SWDC_OUT_BYTES);
	localparam int SWDC_UP_RATIO      = SWDC_LCM_BYTES / SWDC_IN_BYTES;
	localparam int SWDC_DN_RATIO      = SWDC_LCM_BYTES / SWDC_OUT_BYTES;
	localparam int SWDC_BYTE_W        = 8;
	localparam int SWDC_USER_PER_BYTE = 1;
	localparam int SWDC_ID_W          = 4;
	localparam int SWDC_DEST_W        = 4;

	// Derived bus widths
	localparam int SWDC_IN_W    = SWDC_IN_BYTES * SWDC_BYTE_W;
	localparam int SWDC_OUT_W   = SWDC_OUT_BYTES * SWDC_BYTE_W;
	localparam int SWDC_LCM_W   = SWDC_LCM_BYTES * SWDC_BYTE_W;
	localparam int SWDC_IN_UW   = SWDC_IN_BYTES * SWDC_USER_PER_BYTE;
	localparam int SWDC_OUT_UW  = SWDC_OUT_BYTES * SWDC_USER_PER_BYTE;
	localparam int SWDC_LCM_UW  = SWDC_LCM_BYTES * SWDC_USER_PER_BYTE;
	localparam int SWDC_UPC_W   = (SWDC_UP_RATIO > 2) ? $clog2(SWDC_UP_RATIO) : 1;
	localparam int SWDC_DNC_W   = (SWDC_DN_RATIO > 2) ? $clog2(SWDC_DN_RATIO) : 1;

	// Last slot indices
	localparam logic [SWDC_UPC_W-1:0] SWDC_UP_LAST = SWDC_UPC_W'(SWDC_UP_RATIO - 1);
	localparam logic [SWDC_DNC_W-1:0] SWDC_DN_LAST = SWDC_DNC_W'(SWDC_DN_RATIO - 1);

endpackage

// *** core/swdc_downsizer.sv ***
`timescale 1ns/1ps
`default_nettype none

module swdc_downsizer
	import swdc_pkg::*;
(
	input  wire logic                     sys_clk_in,
	input  wire logic                     reset_in,
	input  wire logic                     clk_en_in,
	input  wire logic                     in_tvalid_in,
	output var  logic                     in_tready_out,
	input  wire logic [SWDC_LCM_W-1:0]    in_tdata_in,
	input  wire logic [SWDC_LCM_BYTES-1:0] in_tstrb_in,
	input  wire logic [SWDC_LCM_BYTES-1:0] in_tkeep_in,
	input  wire logic [SWDC_LCM_UW-1:0]   in_tuser_in,
	input  wire logic                     in_tlast_in,
	input  wire logic [SWDC_ID_W-1:0]     in_tid_in,
	input  wire logic [SWDC_DEST_W-1:0]   in_tdest_in,
	output var  logic                     m_tvalid_out,
	input  wire logic                     m_tready_in,
	output var  logic [SWDC_OUT_W-1:0]    m_tdata_out,
	output var  logic [SWDC_OUT_BYTES-1:0] m_tstrb_out,
	output var  logic [SWDC_OUT_BYTES-1:0] m_tkeep_out,
	output var  logic [SWDC_OUT_UW-1:0]   m_tuser_out,
	output var  logic                     m_tlast_out,
	output var  logic [SWDC_ID_W-1:0]     m_tid_out,
	output var  logic [SWDC_DEST_W-1:0]   m_tdest_out
);

	logic [SWDC_LCM_W-1:0]     buf_data_q, buf_data_d;
	logic [SWDC_LCM_BYTES-1:0] buf_strb_q, buf_strb_d;
	logic [SWDC_LCM_BYTES-1:0] buf_keep_q, buf_keep_d;
	logic [SWDC_LCM_UW-1:0]    buf_user_q, buf_user_d;
	logic                      buf_last_q, buf_last_d;
	logic [SWDC_ID_W-1:0]      buf_id_q, buf_id_d;
	logic [SWDC_DEST_W-1:0]    buf_dest_q, buf_dest_d;
	logic                      buf_valid_q, buf_valid_d;
	logic [SWDC_DNC_W-1:0]     pos_q, pos_d;
	logic                      ready_q, ready_d;
	logic                      valid_q, valid_d;
	logic [SWDC_OUT_W-1:0]     data_q, data_d;
	logic [SWDC_OUT_BYTES-1:0] strb_q, strb_d;
	logic [SWDC_OUT_BYTES-1:0] keep_q, keep_d;
	logic [SWDC_OUT_UW-1:0]    user_q, user_d;
	logic                      last_q, last_d;
	logic [SWDC_ID_W-1:0]      id_q, id_d;
	logic [SWDC_DEST_W-1:0]    dest_q, dest_d;

	// Slice the held wide beat, lowest lanes first, one narrow beat per free output slot
	always_comb begin
		buf_data_d  = buf_data_q;
		buf_strb_d  = buf_strb_q;
		buf_keep_d  = buf_keep_q;
		buf_user_d  = buf_user_q;
		buf_last_d  = buf_last_q;
		buf_id_d    = buf_id_q;
		buf_dest_d  = buf_dest_q;
		buf_valid_d = buf_valid_q;
		pos_d       = pos_q;
		valid_d     = valid_q;
		data_d      = data_q;
		strb_d      = strb_q;
		keep_d      = keep_q;
		user_d      = user_q;
		last_d      = last_q;
		id_d        = id_q;
		dest_d      = dest_q;
		if (valid_q && m_tready_in) begin
			valid_d = 1'b0;
		end
		if (buf_valid_q && !valid_d) begin
			data_d  = buf_data_q[pos_q * SWDC_OUT_W +: SWDC_OUT_W];
			strb_d  = buf_strb_q[pos_q * SWDC_OUT_BYTES +: SWDC_OUT_BYTES];
			keep_d  = buf_keep_q[pos_q * SWDC_OUT_BYTES +: SWDC_OUT_BYTES];
			user_d  = buf_user_q[pos_q * SWDC_OUT_UW +: SWDC_OUT_UW];
			last_d  = buf_last_q && (pos_q == SWDC_DN_LAST);
			id_d    = buf_id_q;
			dest_d  = buf_dest_q;
			valid_d = 1'b1;
			if (pos_q == SWDC_DN_LAST) begin
				buf_valid_d = 1'b0;
				pos_d       = '0;
			end else begin
				pos_d = pos_q + 1'b1;
			end
		end
		// Ready is only high while the holding register is empty, so no clash above
		if (ready_q && in_tvalid_in) begin
			buf_data_d  = in_tdata_in;
			buf_strb_d  = in_tstrb_in;
			buf_keep_d  = in_tkeep_in;
			buf_user_d  = in_tuser_in;
			buf_last_d  = in_tlast_in;
			buf_id_d    = in_tid_in;
			buf_dest_d  = in_tdest_in;
			buf_valid_d = 1'b1;
			pos_d       = '0;
		end
		ready_d = !buf_valid_d;
	end

	// Registers; the enable freezes everything
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			buf_data_q  <= '0;
			buf_strb_q  <= '0;
			buf_keep_q  <= '0;
			buf_user_q  <= '0;
			buf_last_q  <= 1'b0;
			buf_id_q    <= '0;
			buf_dest_q  <= '0;
			buf_valid_q <= 1'b0;
			pos_q       <= '0;
			ready_q     <= 1'b0;
			valid_q     <= 1'b0;
			data_q      <= '0;
			strb_q      <= '0;
			keep_q      <= '0;
			user_q      <= '0;
			last_q      <= 1'b0;
			id_q        <= '0;
			dest_q      <= '0;
		end else if (clk_en_in) begin
			buf_data_q  <= buf_data_d;
			buf_strb_q  <= buf_strb_d;
			buf_keep_q  <= buf_keep_d;
			buf_user_q  <= buf_user_d;
			buf_last_q  <= buf_last_d;
			buf_id_q    <= buf_id_d;
			buf_dest_q  <= buf_dest_d;
			buf_valid_q <= buf_valid_d;
			pos_q       <= pos_d;
			ready_q     <= ready_d;
			valid_q     <= valid_d;
			data_q      <= data_d;
			strb_q      <= strb_d;
			keep_q      <= keep_d;
			user_q      <= user_d;
			last_q      <= last_d;
			id_q        <= id_d;
			dest_q      <= dest_d;
		end
	end

	assign in_tready_out = ready_q;
	assign m_tvalid_out  = valid_q;
	assign m_tdata_out   = data_q;
	assign m_tstrb_out   = strb_q;
	assign m_tkeep_out   = keep_q;
	assign m_tuser_out   = user_q;
	assign m_tlast_out   = last_q;
	assign m_tid_out     = id_q;
	assign m_tdest_out   = dest_q;

endmodule

`default_nettype wire

// *** core/swdc_converter.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - User bits per byte equal both sides
// - User bits follow their bytes, uninterpreted
// - Merge only same ID/dest, last only final
// - Flush partial beat on last or ID change
// - Unfilled lanes are null, keep low
// - Odd ratios: up to LCM, then down
// - Whole up ratio done in one stage
// - Whole down ratio done in one stage
// - Up stage: 1-256 in, 2-512 out bytes
// - Up stage latency at least 2 plus N
// - Down stage: 2-512 in, 256-1 out bytes
// - Down stage latency at least two cycles
// - Strobe and keep one bit per byte
// - Sidebands always present, configurable widths
// - One clock, reset, clock enable
module swdc_converter
	import swdc_pkg::*;
(
	input  wire logic                      sys_clk_in,
	input  wire logic                      reset_in,
	input  wire logic                      clk_en_in,
	input  wire logic                      s_tvalid_in,
	output var  logic                      s_tready_out,
	input  wire logic [SWDC_IN_W-1:0]      s_tdata_in,
	input  wire logic [SWDC_IN_BYTES-1:0]  s_tstrb_in,
	input  wire logic [SWDC_IN_BYTES-1:0]  s_tkeep_in,
	input  wire logic [SWDC_IN_UW-1:0]     s_tuser_in,
	input  wire logic                      s_tlast_in,
	input  wire logic [SWDC_ID_W-1:0]      s_tid_in,
	input  wire logic [SWDC_DEST_W-1:0]    s_tdest_in,
	output var  logic                      m_tvalid_out,
	input  wire logic                      m_tready_in,
	output var  logic [SWDC_OUT_W-1:0]     m_tdata_out,
	output var  logic [SWDC_OUT_BYTES-1:0] m_tstrb_out,
	output var  logic [SWDC_OUT_BYTES-1:0] m_tkeep_out,
	output var  logic [SWDC_OUT_UW-1:0]    m_tuser_out,
	output var  logic                      m_tlast_out,
	output var  logic [SWDC_ID_W-1:0]      m_tid_out,
	output var  logic [SWDC_DEST_W-1:0]    m_tdest_out
);

	// Gathering register of the up stage
	logic [SWDC_LCM_W-1:0]     acc_data_q, acc_data_d;
	logic [SWDC_LCM_BYTES-1:0] acc_strb_q, acc_strb_d;
	logic [SWDC_LCM_BYTES-1:0] acc_keep_q, acc_keep_d;
	logic [SWDC_LCM_UW-1:0]    acc_user_q, acc_user_d;
	logic [SWDC_ID_W-1:0]      acc_id_q, acc_id_d;
	logic [SWDC_DEST_W-1:0]    acc_dest_q, acc_dest_d;
	logic [SWDC_UPC_W-1:0]     acc_cnt_q, acc_cnt_d;
	logic                      acc_busy_q, acc_busy_d;
	logic                      acc_flush_q, acc_flush_d;
	// Wide beat handed to the down stage
	logic                      up_valid_q, up_valid_d;
	logic [SWDC_LCM_W-1:0]     up_data_q, up_data_d;
	logic [SWDC_LCM_BYTES-1:0] up_strb_q, up_strb_d;
	logic [SWDC_LCM_BYTES-1:0] up_keep_q, up_keep_d;
	logic [SWDC_LCM_UW-1:0]    up_user_q, up_user_d;
	logic                      up_last_q, up_last_d;
	logic [SWDC_ID_W-1:0]      up_id_q, up_id_d;
	logic [SWDC_DEST_W-1:0]    up_dest_q, up_dest_d;
	logic                      s_ready_q, s_ready_d;
	logic                      dn_ready;
	// Working copies of the gathered beat with the new narrow beat merged in
	logic [SWDC_LCM_W-1:0]     mrg_data;
	logic [SWDC_LCM_BYTES-1:0] mrg_strb;
	logic [SWDC_LCM_BYTES-1:0] mrg_keep;
	logic [SWDC_LCM_UW-1:0]    mrg_user;
	logic [SWDC_UPC_W-1:0]     slot;
	logic                      accept;
	logic                      new_stream;

	// Up stage: place narrow beats into successive lane groups of the wide beat
	always_comb begin
		acc_data_d  = acc_data_q;
		acc_strb_d  = acc_strb_q;
		acc_keep_d  = acc_keep_q;
		acc_user_d  = acc_user_q;
		acc_id_d    = acc_id_q;
		acc_dest_d  = acc_dest_q;
		acc_cnt_d   = acc_cnt_q;
		acc_busy_d  = acc_busy_q;
		acc_flush_d = acc_flush_q;
		up_valid_d  = up_valid_q;
		up_data_d   = up_data_q;
		up_strb_d   = up_strb_q;
		up_keep_d   = up_keep_q;
		up_user_d   = up_user_q;
		up_last_d   = up_last_q;
		up_id_d     = up_id_q;
		up_dest_d   = up_dest_q;
		accept      = s_ready_q && s_tvalid_in;
		new_stream  = acc_busy_q && ((acc_id_q != s_tid_in) || (acc_dest_q != s_tdest_in));
		// Fresh gathers start from null lanes so unfilled lanes leave with keep low
		mrg_data    = acc_busy_q && !new_stream ? acc_data_q : '0;
		mrg_strb    = acc_busy_q && !new_stream ? acc_strb_q : '0;
		mrg_keep    = acc_busy_q && !new_stream ? acc_keep_q : '0;
		mrg_user    = acc_busy_q && !new_stream ? acc_user_q : '0;
		slot        = acc_busy_q && !new_stream ? acc_cnt_q : '0;
		mrg_data[slot * SWDC_IN_W +: SWDC_IN_W]         = s_tdata_in;
		mrg_strb[slot * SWDC_IN_BYTES +: SWDC_IN_BYTES] = s_tstrb_in;
		mrg_keep[slot * SWDC_IN_BYTES +: SWDC_IN_BYTES] = s_tkeep_in;
		mrg_user[slot * SWDC_IN_UW +: SWDC_IN_UW]       = s_tuser_in;
		if (up_valid_q && dn_ready) begin
			up_valid_d = 1'b0;
		end
		if (acc_flush_q && !up_valid_d) begin
			// A last beat opened a new gather while the old one was leaving
			up_data_d   = acc_data_q;
			up_strb_d   = acc_strb_q;
			up_keep_d   = acc_keep_q;
			up_user_d   = acc_user_q;
			up_id_d     = acc_id_q;
			up_dest_d   = acc_dest_q;
			up_last_d   = 1'b1;
			up_valid_d  = 1'b1;
			acc_busy_d  = 1'b0;
			acc_flush_d = 1'b0;
			acc_cnt_d   = '0;
		end else if (accept && new_stream) begin
			// ID or dest changed: ship the partial beat, start over with this one
			up_data_d   = acc_data_q;
			up_strb_d   = acc_strb_q;
			up_keep_d   = acc_keep_q;
			up_user_d   = acc_user_q;
			up_id_d     = acc_id_q;
			up_dest_d   = acc_dest_q;
			up_last_d   = 1'b0;
			up_valid_d  = 1'b1;
			acc_data_d  = mrg_data;
			acc_strb_d  = mrg_strb;
			acc_keep_d  = mrg_keep;
			acc_user_d  = mrg_user;
			acc_id_d    = s_tid_in;
			acc_dest_d  = s_tdest_in;
			acc_cnt_d   = SWDC_UPC_W'(1);
			acc_busy_d  = 1'b1;
			acc_flush_d = s_tlast_in;
		end else if (accept && (s_tlast_in || slot == SWDC_UP_LAST)) begin
			up_data_d   = mrg_data;
			up_strb_d   = mrg_strb;
			up_keep_d   = mrg_keep;
			up_user_d   = mrg_user;
			up_id_d     = s_tid_in;
			up_dest_d   = s_tdest_in;
			up_last_d   = s_tlast_in;
			up_valid_d  = 1'b1;
			acc_busy_d  = 1'b0;
			acc_cnt_d   = '0;
		end else if (accept) begin
			acc_data_d  = mrg_data;
			acc_strb_d  = mrg_strb;
			acc_keep_d  = mrg_keep;
			acc_user_d  = mrg_user;
			acc_id_d    = s_tid_in;
			acc_dest_d  = s_tdest_in;
			acc_cnt_d   = slot + 1'b1;
			acc_busy_d  = 1'b1;
		end
		// Registered ready costs a bubble per wide beat but keeps the port a flop
		s_ready_d = !up_valid_d && !acc_flush_d;
	end

	// Up stage registers
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			acc_data_q  <= '0;
			acc_strb_q  <= '0;
			acc_keep_q  <= '0;
			acc_user_q  <= '0;
			acc_id_q    <= '0;
			acc_dest_q  <= '0;
			acc_cnt_q   <= '0;
			acc_busy_q  <= 1'b0;
			acc_flush_q <= 1'b0;
			up_valid_q  <= 1'b0;
			up_data_q   <= '0;
			up_strb_q   <= '0;
			up_keep_q   <= '0;
			up_user_q   <= '0;
			up_last_q   <= 1'b0;
			up_id_q     <= '0;
			up_dest_q   <= '0;
			s_ready_q   <= 1'b0;
		end else if (clk_en_in) begin
			acc_data_q  <= acc_data_d;
			acc_strb_q  <= acc_strb_d;
			acc_keep_q  <= acc_keep_d;
			acc_user_q  <= acc_user_d;
			acc_id_q    <= acc_id_d;
			acc_dest_q  <= acc_dest_d;
			acc_cnt_q   <= acc_cnt_d;
			acc_busy_q  <= acc_busy_d;
			acc_flush_q <= acc_flush_d;
			up_valid_q  <= up_valid_d;
			up_data_q   <= up_data_d;
			up_strb_q   <= up_strb_d;
			up_keep_q   <= up_keep_d;
			up_user_q   <= up_user_d;
			up_last_q   <= up_last_d;
			up_id_q     <= up_id_d;
			up_dest_q   <= up_dest_d;
			s_ready_q   <= s_ready_d;
		end
	end

	assign s_tready_out = s_ready_q;

	// Down stage from the common multiple width to the output width
	swdc_downsizer u_down (
		.sys_clk_in    (sys_clk_in),
		.reset_in      (reset_in),
		.clk_en_in     (clk_en_in),
		.in_tvalid_in  (up_valid_q),
		.in_tready_out (dn_ready),
		.in_tdata_in   (up_data_q),
		.in_tstrb_in   (up_strb_q),
		.in_tkeep_in   (up_keep_q),
		.in_tuser_in   (up_user_q),
		.in_tlast_in   (up_last_q),
		.in_tid_in     (up_id_q),
		.in_tdest_in   (up_dest_q),
		.m_tvalid_out  (m_tvalid_out),
		.m_tready_in   (m_tready_in),
		.m_tdata_out   (m_tdata_out),
		.m_tstrb_out   (m_tstrb_out),
		.m_tkeep_out   (m_tkeep_out),
		.m_tuser_out   (m_tuser_out),
		.m_tlast_out   (m_tlast_out),
		.m_tid_out     (m_tid_out),
		.m_tdest_out   (m_tdest_out)
	);

endmodule

`default_nettype wire

// *** testbench/swdc_converter_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

// Pin-level watch on the converter; sees only its ports
module swdc_converter_checker
	import swdc_pkg::*;
(
	input wire logic                      sys_clk_in,
	input wire logic                      reset_in,
	input wire logic                      clk_en_in,
	input wire logic                      s_tvalid_in,
	input wire logic                      s_tready_out,
	input wire logic                      s_tlast_in,
	input wire logic                      m_tvalid_out,
	input wire logic                      m_tready_in,
	input wire logic [SWDC_OUT_W-1:0]     m_tdata_out,
	input wire logic [SWDC_OUT_BYTES-1:0] m_tstrb_out,
	input wire logic [SWDC_OUT_BYTES-1:0] m_tkeep_out,
	input wire logic [SWDC_OUT_UW-1:0]    m_tuser_out,
	input wire logic                      m_tlast_out,
	input wire logic [SWDC_ID_W-1:0]      m_tid_out,
	input wire logic [SWDC_DEST_W-1:0]    m_tdest_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	logic                             in_hs;
	logic                             out_hs;
	logic                             null_bad;
	logic                             odd_q;
	logic                             odd_d;
	logic [SWDC_ID_W+SWDC_DEST_W-1:0] tag_q;
	logic [SWDC_ID_W+SWDC_DEST_W-1:0] tag_d;

	// Handshakes count only on enabled edges
	assign in_hs  = clk_en_in && s_tvalid_in && s_tready_out;
	assign out_hs = clk_en_in && m_tvalid_out && m_tready_in;

	// A lane without keep must be empty in every field
	always_comb begin
		null_bad = 1'b0;
		for (int i = 0; i < SWDC_OUT_BYTES; i++) begin
			if (!m_tkeep_out[i] && (m_tdata_out[8*i +: 8] != 8'h00 || m_tstrb_out[i]
			    || m_tuser_out[i]))
				null_bad = 1'b1;
		end
	end

	// Pieces leave in pairs; the route of the last piece is kept for its partner
	always_comb begin
		odd_d = odd_q;
		tag_d = tag_q;
		if (out_hs) begin
			odd_d = !odd_q;
			tag_d = {m_tid_out, m_tdest_out};
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			odd_q <= 1'b0;
			tag_q <= 8'h00;
		end else begin
			odd_q <= odd_d;
			tag_q <= tag_d;
		end
	end

	property p_hold;
		m_tvalid_out && !out_hs |=> m_tvalid_out && $stable({m_tdata_out, m_tkeep_out,
		    m_tstrb_out, m_tuser_out, m_tlast_out, m_tid_out, m_tdest_out});
	endproperty
	a_hold: assert property (p_hold) else $error("output beat changed before taken");
	property p_null; m_tvalid_out |-> !null_bad; endproperty
	a_null: assert property (p_null) else $error("unkept lane not empty");
	property p_idle; $past(reset_in) |-> !m_tvalid_out && !s_tready_out; endproperty
	a_idle: assert property (p_idle) else $error("busy right after reset");
	property p_freeze;
		!clk_en_in |=> $stable({m_tvalid_out, s_tready_out, m_tdata_out, m_tlast_out});
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");
	property p_last_pair; m_tvalid_out && m_tlast_out |-> odd_q; endproperty
	a_last_pair: assert property (p_last_pair) else $error("last on first piece");
	property p_route; m_tvalid_out && odd_q |-> {m_tid_out, m_tdest_out} == tag_q; endproperty
	a_route: assert property (p_route) else $error("route differs within pair");
	property p_stall; in_hs && s_tlast_in |=> !s_tready_out; endproperty
	a_stall: assert property (p_stall) else $error("input not closed after last");
	property p_last_out; in_hs && s_tlast_in |-> ##[2:200] (out_hs && m_tlast_out); endproperty
	a_last_out: assert property (p_last_out) else $error("packet end not passed on");

	c_null: cover property (out_hs && m_tkeep_out == 6'h00);
	c_last: cover property (out_hs && m_tlast_out);
	c_frozen: cover property (!clk_en_in && m_tvalid_out && m_tready_in);
endmodule

bind swdc_converter swdc_converter_checker i_chk (
	.sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
	.s_tvalid_in(s_tvalid_in), .s_tready_out(s_tready_out), .s_tlast_in(s_tlast_in),
	.m_tvalid_out(m_tvalid_out), .m_tready_in(m_tready_in), .m_tdata_out(m_tdata_out),
	.m_tstrb_out(m_tstrb_out), .m_tkeep_out(m_tkeep_out), .m_tuser_out(m_tuser_out),
	.m_tlast_out(m_tlast_out), .m_tid_out(m_tid_out), .m_tdest_out(m_tdest_out)
);
`default_nettype wire

// *** testbench/swdc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none

// Upstream beat source and downstream sink around the converter
module swdc_partner
	import swdc_pkg::*;
#(
	parameter int BW = 53
)
(
	input  wire logic          sys_clk_in,
	input  wire logic          reset_in,
	input  wire logic          clk_en_in,
	input  wire logic          slow_in,
	input  wire logic [1:0]    rnd_in,
	input  wire logic          s_tready_in,
	output var  logic          s_tvalid_out,
	output var  logic [BW-1:0] s_beat_out,
	output var  logic          m_tready_out
);
	logic [BW-1:0] beat_q[$];
	logic          v_q = 1'b0;
	logic          r_q = 1'b0;
	logic [BW-1:0] b_q = '0;

	assign s_tvalid_out = v_q;
	assign s_beat_out   = b_q;
	assign m_tready_out = r_q;

	task automatic send(input logic [BW-1:0] b);
		beat_q.push_back(b);
	endtask

	// Both sides move just after the edge; a slow mode adds gaps and stalls
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			v_q <= 1'b0;
			r_q <= 1'b0;
			beat_q.delete();
		end else begin
			r_q <= !slow_in || rnd_in[1];
			if (v_q && !(s_tready_in && clk_en_in)) begin
				v_q <= 1'b1;
			end else if (beat_q.size() > 0 && (!slow_in || rnd_in[0])) begin
				v_q <= 1'b1;
				b_q <= beat_q.pop_front();
			end else begin
				v_q <= 1'b0;
				b_q <= ~b_q; // Released payload toggles so stale data is never mistaken
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/swdc_converter_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module swdc_converter_test
	import swdc_pkg::*;
;
	localparam int BW = SWDC_IN_W + 3 * SWDC_IN_BYTES + 1 + SWDC_ID_W + SWDC_DEST_W;
	localparam int EW = SWDC_OUT_W + 3 * SWDC_OUT_BYTES + 1 + SWDC_ID_W + SWDC_DEST_W;

	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	logic                      ce = 1'b1;
	logic                      rce = 1'b0;
	logic                      slow = 1'b0;
	logic [1:0]                rnd = 2'h0;
	wire                       sv;
	wire                       sr;
	wire [BW-1:0]              sb;
	wire                       mv;
	wire                       mr;
	wire [SWDC_OUT_W-1:0]      md;
	wire [SWDC_OUT_BYTES-1:0]  ms;
	wire [SWDC_OUT_BYTES-1:0]  mk;
	wire [SWDC_OUT_UW-1:0]     mu;
	wire                       ml;
	wire [7:0]                 mt;
	logic [EW-1:0]             exp_q[$];
	logic [SWDC_LCM_W-1:0]     wd;
	logic [SWDC_LCM_BYTES-1:0] ws;
	logic [SWDC_LCM_BYTES-1:0] wk;
	logic [SWDC_LCM_UW-1:0]    wu;
	logic [7:0]                wr;
	int                        n;
	int                        seed = 27;
	int                        error_cnt = 0;
	int                        tests_run = 0;

	swdc_converter i_dut (
		.sys_clk_in(clk), .reset_in(rst), .clk_en_in(ce), .s_tvalid_in(sv),
		.s_tready_out(sr), .s_tdata_in(sb[52:21]), .s_tstrb_in(sb[20:17]),
		.s_tkeep_in(sb[16:13]), .s_tuser_in(sb[12:9]), .s_tlast_in(sb[8]),
		.s_tid_in(sb[7:4]), .s_tdest_in(sb[3:0]), .m_tvalid_out(mv), .m_tready_in(mr),
		.m_tdata_out(md), .m_tstrb_out(ms), .m_tkeep_out(mk), .m_tuser_out(mu),
		.m_tlast_out(ml), .m_tid_out(mt[7:4]), .m_tdest_out(mt[3:0])
	);
	swdc_partner #(.BW(BW)) i_prt (
		.sys_clk_in(clk), .reset_in(rst), .clk_en_in(ce), .slow_in(slow), .rnd_in(rnd),
		.s_tready_in(sr), .s_tvalid_out(sv), .s_beat_out(sb), .m_tready_out(mr)
	);

	always #50 clk = ~clk;

	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [EW-1:0] e, input logic [EW-1:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t exp %h got %h", $time, e, g);
		end
	endtask

	// Model: empty the wide beat being gathered
	task automatic clr();
		wd = '0;
		ws = '0;
		wk = '0;
		wu = '0;
		n = 0;
	endtask

	// Model: a wide beat leaves as two pieces, low lanes first, last on the second
	task automatic flush(input logic l);
		exp_q.push_back({wd[47:0], ws[5:0], wk[5:0], wu[5:0], 1'b0, wr});
		exp_q.push_back({wd[95:48], ws[11:6], wk[11:6], wu[11:6], l, wr});
		clr();
	endtask

	// Model and source fed together; a route change closes the partial beat
	task automatic put(input logic [31:0] d, input logic [3:0] s, input logic [3:0] u,
	                   input logic l, input logic [7:0] r);
		if (n > 0 && r != wr)
			flush(1'b0);
		wd[n*32 +: 32] = d;
		ws[n*4 +: 4] = s;
		wk[n*4 +: 4] = 4'hF;
		wu[n*4 +: 4] = u;
		wr = r;
		n++;
		if (l || n == 3)
			flush(l);
		i_prt.send({d, s, 4'hF, u, l, r});
	endtask

	// Bounded wait until every queued beat has come out
	task automatic drain();
		int k;
		k = 0;
		// Random phase with stalls on both sides can need several hundred cycles
		while ((exp_q.size() > 0 || i_prt.beat_q.size() > 0) && k < 1500) begin
			@(posedge clk);
			k++;
		end
		chk(EW'(0), EW'(exp_q.size()));
		repeat (4) @(negedge clk);
	endtask

	// Random gaps, stalls and disabled edges
	always @(posedge clk) begin
		rnd <= 2'($random(seed));
		ce <= !rce || ($random(seed) % 4 != 0);
	end

	// Every accepted piece is compared with the model
	always @(posedge clk) begin
		if (!rst && ce && mv && mr)
			chk((exp_q.size() > 0) ? exp_q.pop_front() : {EW{1'bx}}, {md, ms, mk, mu, ml, mt});
	end

	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		int r;
		clr();
		wr = 8'h00;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(EW'(1), EW'(sr));
		// Whole wide beats back to back
		for (int i = 0; i < 6; i++)
			put($random(seed), 4'hF, i[3:0], i == 5, 8'h12);
		drain();
		// Short packets and route changes leave partly null pieces
		put(32'hA1B2C3D4, 4'h5, 4'hA, 1'b1, 8'h00);
		put(32'h01020304, 4'hF, 4'h3, 1'b0, 8'h11);
		put(32'h05060708, 4'h9, 4'hC, 1'b1, 8'h11);
		put(32'h11223344, 4'hF, 4'h1, 1'b0, 8'h21);
		put(32'h55667788, 4'h3, 4'h2, 1'b1, 8'h22);
		drain();
		// Random traffic with stalls on both sides and disabled edges
		@(posedge clk);
		slow <= 1'b1;
		rce <= 1'b1;
		@(negedge clk);
		for (int i = 0; i < 60; i++) begin
			r = $random(seed);
			put(r, r[3:0], r[7:4], i == 59 || r[10:8] == 0, {3'h0, r[11], 3'h0, r[12]});
		end
		drain();
		@(posedge clk);
		slow <= 1'b0;
		rce <= 1'b0;
		// Reset while a partial beat sits inside must drop it
		@(negedge clk);
		put(32'h0BADF00D, 4'hF, 4'h6, 1'b0, 8'h33);
		repeat (6) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		clr();
		@(negedge clk);
		put(32'hCAFE0001, 4'hF, 4'h7, 1'b0, 8'h33);
		put(32'hCAFE0002, 4'hE, 4'h8, 1'b1, 8'h33);
		drain();
		give_verdict();
	end
endmodule
`default_nettype wire
